// ===== src/clkgen_pkg.sv
// constants shared by the clock control device, its host end and the bank generator
// Contract
// - bank enable pin low three-states bank
// - enable pins act without output clock alignment
// - host prefers register enables in running systems
// - two-bit select source chosen by bit0
// - select source bit resets to pins
// - without serial access, pins set frequency
// - host clears source bit before register select
// - source bit zero uses register select bits
// - bank A bits 2:1, bank B 4:3
// - spread pin low enables spreading
// - spread pin pulled high when undriven
// - register spread: bit0 low, then bit6 low
// - bit5 zero one percent, one half percent
// - spreading only lowers frequency, never raises
package clkgen_pkg;
  // device register indices
  localparam logic [1:0] REG_FUNC = 2'h0;
  localparam logic [1:0] REG_BANK_A_EN = 2'h1;
  localparam logic [1:0] REG_BANK_B_EN = 2'h2;
  // function register fields
  localparam int unsigned SRC_BIT = 0;
  localparam int unsigned A_SEL_LSB = 1;
  localparam int unsigned B_SEL_LSB = 3;
  localparam int unsigned WIDTH_BIT = 5;
  localparam int unsigned SPREAD_BIT = 6;
  // power-up values
  localparam logic [7:0] FUNC_RST = 8'hA1;
  localparam logic [7:0] EN_RST = 8'hFF;
  // reference half period in clk cycles, divisible by 1..4
  localparam int unsigned BASE_HALF = 12;
  localparam int unsigned HALF_W = 4;
  // spread accumulator: stall when acc passes modulus
  localparam logic [15:0] SPREAD_MOD = 16'h0640;
  localparam logic [7:0] PEAK_WIDE = 8'h10;
  localparam logic [7:0] PEAK_NARROW = 8'h08;
  localparam logic [11:0] RAMP_CYC = 12'h0100;
  // host apb offsets
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_CMD = 8'h04;
  localparam logic [7:0] APB_STAT = 8'h08;
  // host control register fields
  localparam int unsigned CTRL_OE_A = 0;
  localparam int unsigned CTRL_OE_B = 1;
  localparam int unsigned CTRL_A_SEL = 2;
  localparam int unsigned CTRL_B_SEL = 4;
  localparam int unsigned CTRL_SPREAD = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  // command register fields
  localparam int unsigned CMD_IDX = 0;
  localparam int unsigned CMD_DATA = 8;
endpackage

// ===== src/clkgen_if.sv
// pins and parallel register port between the clock device and its host
`timescale 1ns/10ps
interface clkgen_if #(parameter int unsigned NOUT = 5);
  // strap pins driven by the host side
  logic bank_a_output_enable;
  logic bank_b_output_enable;
  logic bank_a_freq_select_msb;
  logic bank_a_freq_select_lsb;
  logic bank_b_freq_select_msb;
  logic bank_b_freq_select_lsb;
  // open-drain spread pin with pull-up
  logic spread_enable_n_drv;
  logic spread_enable_n_oe_n;
  logic spread_enable_n;
  // register port
  logic [1:0] reg_sel;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  // clock outputs, enable low while driven
  logic [NOUT-1:0] bank_a_clock_outputs;
  logic [NOUT-1:0] bank_a_clock_oe_n;
  logic [NOUT-1:0] bank_b_clock_outputs;
  logic [NOUT-1:0] bank_b_clock_oe_n;

  assign spread_enable_n = spread_enable_n_oe_n ? 1'b1 : spread_enable_n_drv;

  modport dev (
    input bank_a_output_enable, bank_b_output_enable,
    input bank_a_freq_select_msb, bank_a_freq_select_lsb,
    input bank_b_freq_select_msb, bank_b_freq_select_lsb,
    input spread_enable_n,
    input reg_sel, reg_wr, reg_wdata,
    output reg_rdata,
    output bank_a_clock_outputs, bank_a_clock_oe_n,
    output bank_b_clock_outputs, bank_b_clock_oe_n
  );
  modport host (
    output bank_a_output_enable, bank_b_output_enable,
    output bank_a_freq_select_msb, bank_a_freq_select_lsb,
    output bank_b_freq_select_msb, bank_b_freq_select_lsb,
    output spread_enable_n_drv, spread_enable_n_oe_n,
    output reg_sel, reg_wr, reg_wdata,
    input reg_rdata
  );
endinterface

// ===== src/clk_bank.sv
// one output bank: multiple-of-reference divider and glitch-free per-output gates
`timescale 1ns/10ps
module clk_bank #(
  parameter int unsigned NOUT = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // control
  input wire logic run_i,
  input wire logic [1:0] mult_i,
  input wire logic [NOUT-1:0] reg_en_i,
  input wire logic bank_oe_i,
  // outputs
  output logic [NOUT-1:0] clk_o,
  output logic [NOUT-1:0] oe_n_o
);
  // elaboration-time parameter checks
  if (NOUT < 1 || NOUT > 8)
  begin : gen_bad_nout
    $error("clk_bank: NOUT out of range");
  end
  if (clkgen_pkg::BASE_HALF % 12 != 0 || clkgen_pkg::BASE_HALF >= (1 << clkgen_pkg::HALF_W))
  begin : gen_bad_half
    $error("clk_bank: BASE_HALF unusable");
  end

  function automatic logic [clkgen_pkg::HALF_W-1:0] half_len(input logic [1:0] m);
    case (m)
      2'h0: half_len = clkgen_pkg::HALF_W'(clkgen_pkg::BASE_HALF);
      2'h1: half_len = clkgen_pkg::HALF_W'(clkgen_pkg::BASE_HALF / 2);
      2'h2: half_len = clkgen_pkg::HALF_W'(clkgen_pkg::BASE_HALF / 3);
      default: half_len = clkgen_pkg::HALF_W'(clkgen_pkg::BASE_HALF / 4);
    endcase
  endfunction

  logic [clkgen_pkg::HALF_W-1:0] cnt_r;
  logic phase_r;
  logic [NOUT-1:0] run_r;

  // divider; a stalled cycle stretches the period only
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt_r <= '0;
      phase_r <= 1'b0;
    end
    else if (run_i)
    begin
      if (cnt_r == '0)
      begin
        cnt_r <= half_len(mult_i) - 1'b1;
        phase_r <= ~phase_r;
      end
      else
        cnt_r <= cnt_r - 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NOUT; g++)
    begin : gen_out
      // gate changes only while the clock is low
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          run_r[g] <= 1'b1;
        else if (!phase_r)
          run_r[g] <= reg_en_i[g];
      end
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          clk_o[g] <= 1'b0;
        else
          clk_o[g] <= phase_r & (run_r[g] | !phase_r) & (reg_en_i[g] | run_r[g]);
      end
      assign oe_n_o[g] = ~bank_oe_i;
    end
  endgenerate
endmodule

// ===== src/clkgen_device.sv
// clock generator control: strap sync, function registers, spread modulation, two banks
`timescale 1ns/10ps
module clkgen_device #(
  parameter int unsigned NOUT = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // link to host
  clkgen_if.dev link,
  // user-side status
  output logic [1:0] bank_a_mult_o,
  output logic [1:0] bank_b_mult_o,
  output logic spread_active_o,
  output logic [7:0] spread_rate_o
);
  // elaboration-time parameter check
  if (NOUT < 1 || NOUT > 8)
  begin : gen_bad_nout
    $error("clkgen_device: NOUT out of range");
  end

  typedef enum logic [1:0] {
    RAMP_UP = 2'b00,
    RAMP_DOWN = 2'b01,
    RAMP_IDLE = 2'b10
  } ramp_state_t;

  // pin synchronisers
  logic [6:0] pin_meta_r;
  logic [6:0] pin_sync_r;
  logic oe_a;
  logic oe_b;
  logic [1:0] pin_a_sel;
  logic [1:0] pin_b_sel;
  logic spread_pin_n;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_meta_r <= 7'h40;
      pin_sync_r <= 7'h40;
    end
    else
    begin
      pin_meta_r <= {link.spread_enable_n,
                     link.bank_b_freq_select_msb, link.bank_b_freq_select_lsb,
                     link.bank_a_freq_select_msb, link.bank_a_freq_select_lsb,
                     link.bank_b_output_enable, link.bank_a_output_enable};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign oe_a = pin_sync_r[0];
  assign oe_b = pin_sync_r[1];
  assign pin_a_sel = pin_sync_r[3:2];
  assign pin_b_sel = pin_sync_r[5:4];
  assign spread_pin_n = pin_sync_r[6];

  // device registers
  logic [7:0] func_r;
  logic [NOUT-1:0] en_a_r;
  logic [NOUT-1:0] en_b_r;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      func_r <= clkgen_pkg::FUNC_RST;
    else if (link.reg_wr && link.reg_sel == clkgen_pkg::REG_FUNC)
      func_r <= link.reg_wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      en_a_r <= clkgen_pkg::EN_RST[NOUT-1:0];
      en_b_r <= clkgen_pkg::EN_RST[NOUT-1:0];
    end
    else if (link.reg_wr)
    begin
      if (link.reg_sel == clkgen_pkg::REG_BANK_A_EN)
        en_a_r <= link.reg_wdata[NOUT-1:0];
      if (link.reg_sel == clkgen_pkg::REG_BANK_B_EN)
        en_b_r <= link.reg_wdata[NOUT-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      link.reg_rdata <= 8'h00;
    else
    begin
      case (link.reg_sel)
        clkgen_pkg::REG_FUNC: link.reg_rdata <= func_r;
        clkgen_pkg::REG_BANK_A_EN: link.reg_rdata <= 8'(en_a_r);
        clkgen_pkg::REG_BANK_B_EN: link.reg_rdata <= 8'(en_b_r);
        default: link.reg_rdata <= 8'h00;
      endcase
    end
  end

  // frequency and spread source selection
  logic select_source_bit;
  logic [1:0] a_sel;
  logic [1:0] b_sel;
  logic spread_on;
  logic narrow;

  assign select_source_bit = func_r[clkgen_pkg::SRC_BIT];
  assign a_sel = select_source_bit ? pin_a_sel
                 : func_r[clkgen_pkg::A_SEL_LSB +: 2];
  assign b_sel = select_source_bit ? pin_b_sel
                 : func_r[clkgen_pkg::B_SEL_LSB +: 2];
  assign spread_on = select_source_bit ? ~spread_pin_n
                     : ~func_r[clkgen_pkg::SPREAD_BIT];
  assign narrow = func_r[clkgen_pkg::WIDTH_BIT];

  // triangular spread profile
  ramp_state_t ramp_r;
  logic [7:0] rate_r;
  logic [11:0] ramp_cnt_r;
  logic [7:0] peak;
  logic ramp_step;

  assign peak = narrow ? clkgen_pkg::PEAK_NARROW : clkgen_pkg::PEAK_WIDE;
  assign ramp_step = (ramp_cnt_r == clkgen_pkg::RAMP_CYC - 1'b1);

  always_ff @(posedge clk_i)
  begin
    if (srst_i || !spread_on || ramp_step)
      ramp_cnt_r <= 12'h000;
    else
      ramp_cnt_r <= ramp_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ramp_r <= RAMP_IDLE;
      rate_r <= 8'h00;
    end
    else
    begin
      case (ramp_r)
        RAMP_IDLE:
        begin
          rate_r <= 8'h00;
          if (spread_on)
            ramp_r <= RAMP_UP;
        end
        RAMP_UP:
        begin
          if (!spread_on)
            ramp_r <= RAMP_IDLE;
          else if (rate_r >= peak)
          begin
            rate_r <= peak;
            ramp_r <= RAMP_DOWN;
          end
          else if (ramp_step)
            rate_r <= rate_r + 1'b1;
        end
        RAMP_DOWN:
        begin
          if (!spread_on)
            ramp_r <= RAMP_IDLE;
          else if (rate_r == 8'h00)
            ramp_r <= RAMP_UP;
          else if (ramp_step)
            rate_r <= rate_r - 1'b1;
        end
        default:
          ramp_r <= RAMP_IDLE;
      endcase
    end
  end

  // stall accumulator: removes cycles, so frequency only drops
  logic [15:0] acc_r;
  logic stall_r;
  logic [15:0] acc_sum;

  assign acc_sum = acc_r + 16'(rate_r);

  always_ff @(posedge clk_i)
  begin
    if (srst_i || ramp_r == RAMP_IDLE)
    begin
      acc_r <= 16'h0000;
      stall_r <= 1'b0;
    end
    else if (acc_sum >= clkgen_pkg::SPREAD_MOD)
    begin
      acc_r <= acc_sum - clkgen_pkg::SPREAD_MOD;
      stall_r <= 1'b1;
    end
    else
    begin
      acc_r <= acc_sum;
      stall_r <= 1'b0;
    end
  end

  // banks
  clk_bank #(.NOUT(NOUT)) u_bank_a (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(~stall_r),
    .mult_i(a_sel),
    .reg_en_i(en_a_r),
    .bank_oe_i(oe_a),
    .clk_o(link.bank_a_clock_outputs),
    .oe_n_o(link.bank_a_clock_oe_n)
  );

  clk_bank #(.NOUT(NOUT)) u_bank_b (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(~stall_r),
    .mult_i(b_sel),
    .reg_en_i(en_b_r),
    .bank_oe_i(oe_b),
    .clk_o(link.bank_b_clock_outputs),
    .oe_n_o(link.bank_b_clock_oe_n)
  );

  // status outputs
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      bank_a_mult_o <= 2'h0;
      bank_b_mult_o <= 2'h0;
      spread_active_o <= 1'b0;
      spread_rate_o <= 8'h00;
    end
    else
    begin
      bank_a_mult_o <= a_sel;
      bank_b_mult_o <= b_sel;
      spread_active_o <= spread_on;
      spread_rate_o <= rate_r;
    end
  end
endmodule

// ===== src/clkgen_host.sv
// host end: apb slave driving strap pins and issuing device register writes
`timescale 1ns/10ps
module clkgen_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // link to device
  clkgen_if.host link
);
  logic [31:0] ctrl_r;
  logic [1:0] idx_r;
  logic wr_r;
  logic [7:0] wdata_r;
  logic access;

  assign access = psel_i & penable_i;
  assign pready_o = 1'b1;
  assign pslverr_o = access & (paddr_i != clkgen_pkg::APB_CTRL)
                     & (paddr_i != clkgen_pkg::APB_CMD) & (paddr_i != clkgen_pkg::APB_STAT);

  // strap pin control register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ctrl_r <= clkgen_pkg::CTRL_RST;
    else if (access && pwrite_i && paddr_i == clkgen_pkg::APB_CTRL)
      ctrl_r <= pwdata_i;
  end

  assign link.bank_a_output_enable = ctrl_r[clkgen_pkg::CTRL_OE_A];
  assign link.bank_b_output_enable = ctrl_r[clkgen_pkg::CTRL_OE_B];
  assign link.bank_a_freq_select_lsb = ctrl_r[clkgen_pkg::CTRL_A_SEL];
  assign link.bank_a_freq_select_msb = ctrl_r[clkgen_pkg::CTRL_A_SEL + 1];
  assign link.bank_b_freq_select_lsb = ctrl_r[clkgen_pkg::CTRL_B_SEL];
  assign link.bank_b_freq_select_msb = ctrl_r[clkgen_pkg::CTRL_B_SEL + 1];
  assign link.spread_enable_n_drv = 1'b0;
  assign link.spread_enable_n_oe_n = ~ctrl_r[clkgen_pkg::CTRL_SPREAD];

  // device register write, one-cycle strobe
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      idx_r <= 2'h0;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
    end
    else if (access && pwrite_i && paddr_i == clkgen_pkg::APB_CMD)
    begin
      idx_r <= pwdata_i[clkgen_pkg::CMD_IDX +: 2];
      wdata_r <= pwdata_i[clkgen_pkg::CMD_DATA +: 8];
      wr_r <= 1'b1;
    end
    else
      wr_r <= 1'b0;
  end

  assign link.reg_sel = idx_r;
  assign link.reg_wr = wr_r;
  assign link.reg_wdata = wdata_r;

  always_comb
  begin
    prdata_o = 32'h0000_0000;
    case (paddr_i)
      clkgen_pkg::APB_CTRL: prdata_o = ctrl_r;
      clkgen_pkg::APB_CMD: prdata_o = {16'h0000, wdata_r, 6'h00, idx_r};
      clkgen_pkg::APB_STAT: prdata_o = {24'h00_0000, link.reg_rdata};
      default: prdata_o = 32'h0000_0000;
    endcase
  end
endmodule

// ===== verif/clkgen_chk.sv
// concurrent checks on the link between host and clock device
`timescale 1ns/10ps
module clkgen_chk #(
  parameter int unsigned NOUT = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // strap and spread pins
  input wire logic bank_a_output_enable,
  input wire logic bank_b_output_enable,
  input wire logic spread_enable_n_drv,
  input wire logic spread_enable_n_oe_n,
  input wire logic spread_enable_n,
  // register port
  input wire logic [1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // clock outputs
  input wire logic [NOUT-1:0] bank_a_clock_outputs,
  input wire logic [NOUT-1:0] bank_a_clock_oe_n,
  input wire logic [NOUT-1:0] bank_b_clock_outputs,
  input wire logic [NOUT-1:0] bank_b_clock_oe_n
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  property p_off_a;
    (!srst_i && !bank_a_output_enable)[*3] |-> &bank_a_clock_oe_n;
  endproperty
  a_off_a: assert property (p_off_a) else $error("bank a driven while pin low");
  property p_on_b;
    (!srst_i && bank_b_output_enable)[*4] |-> bank_b_clock_oe_n == '0;
  endproperty
  a_on_b: assert property (p_on_b) else $error("bank b not driven while pin high");
  property p_fall_b;
    $fell(bank_b_output_enable) ##1 (!bank_b_output_enable)[*2] |-> &bank_b_clock_oe_n;
  endproperty
  a_fall_b: assert property (p_fall_b) else $error("bank b release too slow");
  property p_runt_a;
    $rose(bank_a_clock_outputs[0]) |=> bank_a_clock_outputs[0];
  endproperty
  a_runt_a: assert property (p_runt_a) else $error("runt high pulse on bank a");
  property p_low_b;
    $fell(bank_b_clock_outputs[0]) |=> !bank_b_clock_outputs[0];
  endproperty
  a_low_b: assert property (p_low_b) else $error("runt low pulse on bank b");
  property p_half_a;
    $rose(bank_a_clock_outputs[1]) |-> ##[1:16] !bank_a_clock_outputs[1];
  endproperty
  a_half_a: assert property (p_half_a) else $error("bank a high phase too long");
  property p_rd_func;
    (reg_wr && reg_sel == 2'h0) ##1 (!reg_wr && reg_sel == 2'h0)
      |=> ($past(reg_wdata, 2) & 8'h7F) == (reg_rdata & 8'h7F);
  endproperty
  a_rd_func: assert property (p_rd_func) else $error("function register not updated");
  property p_pin;
    spread_enable_n == (spread_enable_n_oe_n | spread_enable_n_drv);
  endproperty
  a_pin: assert property (p_pin) else $error("spread pin level wrong");

  cover property ($fell(bank_a_output_enable));
  cover property (reg_wr && reg_sel == 2'h0);
  cover property ($rose(bank_b_clock_outputs[0]));
endmodule

// ===== verif/clock_output_freq_spread_ctrl_tb.sv
// self-checking bench joining host and device ends over the link
`timescale 1ns/10ps
module clock_output_freq_spread_ctrl_tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [1:0] ea;
    logic [1:0] eb;
    logic es;
    logic [7:0] peak;
  } row_t;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [1:0] bank_a_mult_o;
  logic [1:0] bank_b_mult_o;
  logic spread_active_o;
  logic [7:0] spread_rate_o;
  int errors = 0;
  int checks_done = 0;
  row_t rows [0:10];

  always #2.5 clk_i = ~clk_i;

  clkgen_if #(.NOUT(5)) link_if();
  clkgen_host i_clkgen_host(.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .link(link_if));
  clkgen_device #(.NOUT(5)) i_clkgen_device(.clk_i, .srst_i, .link(link_if), .bank_a_mult_o, .bank_b_mult_o,
    .spread_active_o, .spread_rate_o);
  clkgen_chk #(.NOUT(5)) i_clkgen_chk(.clk_i(clk_i), .srst_i(srst_i),
    .bank_a_output_enable(link_if.bank_a_output_enable), .bank_b_output_enable(link_if.bank_b_output_enable),
    .spread_enable_n_drv(link_if.spread_enable_n_drv), .spread_enable_n_oe_n(link_if.spread_enable_n_oe_n),
    .spread_enable_n(link_if.spread_enable_n), .reg_sel(link_if.reg_sel), .reg_wr(link_if.reg_wr),
    .reg_wdata(link_if.reg_wdata), .reg_rdata(link_if.reg_rdata),
    .bank_a_clock_outputs(link_if.bank_a_clock_outputs), .bank_a_clock_oe_n(link_if.bank_a_clock_oe_n),
    .bank_b_clock_outputs(link_if.bank_b_clock_outputs), .bank_b_clock_oe_n(link_if.bank_b_clock_oe_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer, called just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // cycles between two rising edges of bank a output 1
  task automatic measure(output int n);
    int k;
    int t0;
    logic prev;
    n = 0;
    k = 0;
    t0 = -1;
    prev = 1'b1;
    while (k < 200 && n == 0)
    begin
      @(posedge clk_i);
      k++;
      if (prev === 1'b0 && link_if.bank_a_clock_outputs[1] === 1'b1)
      begin
        if (t0 >= 0)
          n = k - t0;
        t0 = k;
      end
      prev = link_if.bank_a_clock_outputs[1];
    end
  endtask

  task automatic do_reset;
    logic [31:0] rd;
    logic err;
    srst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    apb(1'b0, clkgen_pkg::APB_CTRL, 32'h0000_0000, rd, err);
    check(rd, clkgen_pkg::CTRL_RST);
    apb(1'b0, clkgen_pkg::APB_STAT, 32'h0000_0000, rd, err);
    check({24'h0, rd[7:0]}, {24'h0, clkgen_pkg::FUNC_RST});
    check({30'h0, bank_a_mult_o}, 32'h0000_0000);
  endtask

  task automatic oe_case(input logic [31:0] ctrl, input logic [4:0] ea, input logic [4:0] eb);
    logic [31:0] rd;
    logic err;
    apb(1'b1, clkgen_pkg::APB_CTRL, ctrl, rd, err);
    repeat (6) @(posedge clk_i);
    check({27'h0, link_if.bank_a_clock_oe_n}, {27'h0, ea});
    check({27'h0, link_if.bank_b_clock_oe_n}, {27'h0, eb});
  endtask

  // spread sweep on bank a at x1: highest rate, shortest and longest period
  task automatic sweep(input logic [31:0] cmd, input int cyc, input logic [7:0] pk);
    logic [31:0] rd;
    logic err;
    logic [7:0] top;
    logic prev;
    int last;
    int lo;
    int hi;
    apb(1'b1, clkgen_pkg::APB_CMD, cmd, rd, err);
    top = 8'h00;
    prev = 1'b1;
    last = -1;
    lo = 1000;
    hi = 0;
    for (int k = 0; k < cyc; k++)
    begin
      @(posedge clk_i);
      if (spread_rate_o > top)
        top = spread_rate_o;
      if (prev === 1'b0 && link_if.bank_a_clock_outputs[1] === 1'b1)
      begin
        if (last >= 0 && k - last < lo)
          lo = k - last;
        if (last >= 0 && k - last > hi)
          hi = k - last;
        last = k;
      end
      prev = link_if.bank_a_clock_outputs[1];
    end
    check({24'h0, top}, {24'h0, pk});
    check(32'(lo), 32'(2 * clkgen_pkg::BASE_HALF));
    check(32'(hi), 32'(2 * clkgen_pkg::BASE_HALF + 1));
  endtask

  initial
  begin
    #100_000;
    errors++;
    end_sim();
  end

  initial
  begin
    logic [31:0] rd;
    logic err;
    logic [1:0] seen;
    int n;
    int nom;
    rows[0] = '{clkgen_pkg::APB_CTRL, 32'h0000_0033, 2'h0, 2'h3, 1'b0, 8'h00};
    rows[1] = '{clkgen_pkg::APB_CTRL, 32'h0000_0027, 2'h1, 2'h2, 1'b0, 8'h00};
    rows[2] = '{clkgen_pkg::APB_CTRL, 32'h0000_001B, 2'h2, 2'h1, 1'b0, 8'h00};
    rows[3] = '{clkgen_pkg::APB_CTRL, 32'h0000_000F, 2'h3, 2'h0, 1'b0, 8'h00};
    rows[4] = '{clkgen_pkg::APB_CTRL, 32'h0000_004F, 2'h3, 2'h0, 1'b1, clkgen_pkg::PEAK_NARROW};
    rows[5] = '{clkgen_pkg::APB_CTRL, 32'h0000_000F, 2'h3, 2'h0, 1'b0, 8'h00};
    rows[6] = '{clkgen_pkg::APB_CMD, 32'h0000_6000, 2'h0, 2'h0, 1'b0, 8'h00};
    rows[7] = '{clkgen_pkg::APB_CMD, 32'h0000_0A00, 2'h1, 2'h1, 1'b1, clkgen_pkg::PEAK_WIDE};
    rows[8] = '{clkgen_pkg::APB_CMD, 32'h0000_7400, 2'h2, 2'h2, 1'b0, 8'h00};
    rows[9] = '{clkgen_pkg::APB_CMD, 32'h0000_3E00, 2'h3, 2'h3, 1'b1, clkgen_pkg::PEAK_NARROW};
    rows[10] = '{clkgen_pkg::APB_CMD, 32'h0000_0100, 2'h3, 2'h0, 1'b0, 8'h00};
    do_reset();
    for (int i = 0; i <= 10; i++)
    begin
      apb(1'b1, rows[i].addr, rows[i].data, rd, err);
      repeat (8) @(posedge clk_i);
      check({30'h0, bank_a_mult_o}, {30'h0, rows[i].ea});
      check({30'h0, bank_b_mult_o}, {30'h0, rows[i].eb});
      check({31'h0, spread_active_o}, {31'h0, rows[i].es});
      measure(n);
      nom = 2 * clkgen_pkg::BASE_HALF / (int'(rows[i].ea) + 1);
      if (rows[i].es)
      begin
        check({31'h0, n >= nom}, 32'h0000_0001);
        check({31'h0, spread_rate_o <= rows[i].peak}, 32'h0000_0001);
      end
      else
        check(32'(n), 32'(nom));
      if (rows[i].addr == clkgen_pkg::APB_CMD)
      begin
        apb(1'b0, clkgen_pkg::APB_STAT, 32'h0000_0000, rd, err);
        check({24'h0, rd[7:0]}, {24'h0, rows[i].data[15:8]});
      end
    end
    do_reset();
    oe_case(32'h0000_0002, 5'h1F, 5'h00);
    oe_case(32'h0000_0001, 5'h00, 5'h1F);
    oe_case(32'h0000_0003, 5'h00, 5'h00);
    sweep(32'h0000_0000, 4400, clkgen_pkg::PEAK_WIDE);
    apb(1'b1, clkgen_pkg::APB_CMD, 32'h0000_4000, rd, err);
    sweep(32'h0000_2000, 2400, clkgen_pkg::PEAK_NARROW);
    apb(1'b1, clkgen_pkg::APB_CMD, 32'h0000_1E01, rd, err);
    repeat (30) @(posedge clk_i);
    seen = 2'b00;
    repeat (30)
    begin
      @(posedge clk_i);
      seen = seen | link_if.bank_a_clock_outputs[1:0];
    end
    check({30'h0, seen}, 32'h0000_0002);
    apb(1'b1, clkgen_pkg::APB_CMD, 32'h0000_1F01, rd, err);
    apb(1'b0, 8'h0C, 32'h0000_0000, rd, err);
    check({rd[30:0], err}, 32'h0000_0001);
    end_sim();
  end
endmodule
